// [design/rsr_responder.sv]
/*
  Sense responder: per-initiator sense records, the 18-byte sense block,
  truncation to the allocation length and an APB register file.
  Assumes command, error and reset events come as one-cycle pulses from
  logic on pclk, and a byte sink that takes a byte when ready is high.
*/
// Design decisions made here: the APB interface to the registers and the register addresses.
// What this block does
// - Opcode 03h asks for stored sense, length byte4
// - Separate sense record per initiator, eight ids
// - Next command from initiator clears its record
// - Device reset or bus reset clears all
// - Unidentified initiators share one extra slot
// - Check condition leaves valid sense behind
// - Unexpected bus free also leaves sense
// - Wrong unit gives key 5, 25h, 00h
// - No stored error gives key 0, zeros
// - Latest error overwrites stored sense
// - Sense block is exactly 18 bytes
// - Zero allocation length sends nothing
// - Send smaller of allocation and 18
// - Error code 70h if pending, else 0
// - Byte 7 holds constant 0Ah
// - Unsupported fields always read zero
// - Not ready uses key 2
// - Hardware fault uses key 4
// - Illegal request uses key 5
// - Unit attention uses key 6
// - Aborted command uses key 11
// - Key specific valid only for key 5
// - Flag 1 for command, 0 for data
`include "rsr_cfg.svh"
`default_nettype none
module rsr_responder (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command start
  input wire logic cmd_start,
  input wire logic [7:0] cmd_opcode,
  input wire logic [2:0] cmd_lun,
  input wire logic [7:0] cmd_alloc_len,
  input wire logic [2:0] cmd_init_id,
  input wire logic cmd_id_known,
  // Error report for the running command
  input wire logic err_valid,
  input wire rsr_pkg::rsr_ecls_t err_class,
  input wire logic [7:0] err_asc,
  input wire logic [7:0] err_ascq,
  input wire logic err_cd,
  input wire logic err_bpv,
  input wire logic [2:0] err_bit_ptr,
  input wire logic [15:0] err_field_ptr,
  input wire logic bus_free_err,
  // Reset events
  input wire logic bdr_msg,
  input wire logic bus_reset,
  // Sense byte stream
  output logic dout_valid,
  output logic [7:0] dout_byte,
  output logic dout_last,
  input wire logic dout_ready,
  output logic sense_done
);
  import rsr_pkg::*;

  localparam int NSLOT = 9;

  // Sense record store, one entry per slot
  logic [NSLOT-1:0] pend_ff;
  logic [3:0] key_ff [NSLOT];
  logic [7:0] asc_ff [NSLOT];
  logic [7:0] ascq_ff [NSLOT];
  logic [NSLOT-1:0] cd_ff;
  logic [NSLOT-1:0] bpv_ff;
  logic [2:0] bitp_ff [NSLOT];
  logic [15:0] fptr_ff [NSLOT];

  // Snapshot of the record being sent
  logic snap_pend_ff;
  logic [3:0] snap_key_ff;
  logic [7:0] snap_asc_ff;
  logic [7:0] snap_ascq_ff;
  logic snap_cd_ff;
  logic snap_bpv_ff;
  logic [2:0] snap_bitp_ff;
  logic [15:0] snap_fptr_ff;

  rsr_state_t state_ff;
  rsr_state_t nxt_state;
  rsr_slot_t cur_slot_ff;
  logic [4:0] idx_ff;
  logic [4:0] cnt_ff;
  logic dout_valid_ff;
  logic [7:0] dout_byte_ff;
  logic dout_last_ff;
  logic done_ff;
  logic [2:0] unit_ff;
  logic [3:0] sel_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // Slot decode; anonymous initiators share the ninth slot
  wire rsr_slot_t new_slot = cmd_id_known ? {1'b0, cmd_init_id} : `RSR_SLOT_ANON;
  wire is_sense = cmd_start && (cmd_opcode == `RSR_OPC_SENSE);
  wire bad_unit = cmd_lun != unit_ff;
  wire clr_all = bdr_msg || bus_reset;
  wire rec_err = err_valid || bus_free_err;

  // Error class to sense key
  logic [3:0] err_key;
  always_comb
  begin
    case (err_class)
      RSR_EC_NRDY: err_key = `RSR_KEY_NRDY;
      RSR_EC_HW: err_key = `RSR_KEY_HW;
      RSR_EC_ILL: err_key = `RSR_KEY_ILL;
      RSR_EC_UATT: err_key = `RSR_KEY_UATT;
      RSR_EC_ABRT: err_key = `RSR_KEY_ABRT;
      default: err_key = `RSR_KEY_ABRT;
    endcase
  end
  // A dropped bus forces an abort entry, no key-specific data
  wire [3:0] w_key = bus_free_err ? `RSR_KEY_ABRT : err_key;
  wire [7:0] w_asc = bus_free_err ? 8'h00 : err_asc;
  wire [7:0] w_ascq = bus_free_err ? 8'h00 : err_ascq;

  // Allocation cut to the 18 bytes on hand
  wire [4:0] alloc_cut = (cmd_alloc_len < {3'h0, `RSR_SENSE_LEN}) ?
    cmd_alloc_len[4:0] : `RSR_SENSE_LEN;

  // Record store: clears first, then a new error, so the set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_ff <= '0;
      cd_ff <= '0;
      bpv_ff <= '0;
      for (int i = 0; i < NSLOT; i++)
      begin
        key_ff[i] <= `RSR_KEY_NONE;
        asc_ff[i] <= 8'h00;
        ascq_ff[i] <= 8'h00;
        bitp_ff[i] <= 3'h0;
        fptr_ff[i] <= 16'h0000;
      end
    end
    else
    begin
      if (clr_all)
        pend_ff <= '0;
      else if (cmd_start)
        pend_ff[new_slot] <= 1'b0;
      if (rec_err)
      begin
        // Later errors simply overwrite the entry
        pend_ff[cur_slot_ff] <= 1'b1;
        key_ff[cur_slot_ff] <= w_key;
        asc_ff[cur_slot_ff] <= w_asc;
        ascq_ff[cur_slot_ff] <= w_ascq;
        cd_ff[cur_slot_ff] <= err_cd && !bus_free_err;
        bpv_ff[cur_slot_ff] <= err_bpv && !bus_free_err;
        bitp_ff[cur_slot_ff] <= err_bit_ptr;
        fptr_ff[cur_slot_ff] <= err_field_ptr;
      end
    end
  end

  // Current command owner; errors land in its slot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_slot_ff <= 4'h0;
    else if (cmd_start)
      cur_slot_ff <= new_slot;
  end

  // Snapshot taken before the request clears the record
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snap_pend_ff <= 1'b0;
      snap_key_ff <= `RSR_KEY_NONE;
      snap_asc_ff <= 8'h00;
      snap_ascq_ff <= 8'h00;
      snap_cd_ff <= 1'b0;
      snap_bpv_ff <= 1'b0;
      snap_bitp_ff <= 3'h0;
      snap_fptr_ff <= 16'h0000;
    end
    else if (is_sense && state_ff == RSR_IDLE)
    begin
      if (bad_unit)
      begin
        snap_pend_ff <= 1'b1;
        snap_key_ff <= `RSR_KEY_ILL;
        snap_asc_ff <= `RSR_ASC_BADLUN;
        snap_ascq_ff <= `RSR_ASCQ_BADLUN;
        snap_cd_ff <= 1'b0;
        snap_bpv_ff <= 1'b0;
        snap_bitp_ff <= 3'h0;
        snap_fptr_ff <= 16'h0000;
      end
      else
      begin
        snap_pend_ff <= pend_ff[new_slot] && !clr_all;
        snap_key_ff <= key_ff[new_slot];
        snap_asc_ff <= asc_ff[new_slot];
        snap_ascq_ff <= ascq_ff[new_slot];
        snap_cd_ff <= cd_ff[new_slot];
        snap_bpv_ff <= bpv_ff[new_slot];
        snap_bitp_ff <= bitp_ff[new_slot];
        snap_fptr_ff <= fptr_ff[new_slot];
      end
    end
  end

  // Sense block byte for a position; everything unlisted is zero
  wire [3:0] s_key = snap_pend_ff ? snap_key_ff : `RSR_KEY_NONE;
  wire [7:0] s_asc = snap_pend_ff ? snap_asc_ff : 8'h00;
  wire [7:0] s_ascq = snap_pend_ff ? snap_ascq_ff : 8'h00;
  wire s_sksv = snap_pend_ff && (snap_key_ff == `RSR_KEY_ILL);
  wire [7:0] s_sks0 = s_sksv ?
    {1'b1, snap_cd_ff, 2'b00, snap_bpv_ff, snap_bitp_ff} : 8'h00;
  wire [7:0] s_sks1 = s_sksv ? snap_fptr_ff[15:8] : 8'h00;
  wire [7:0] s_sks2 = s_sksv ? snap_fptr_ff[7:0] : 8'h00;

  function automatic logic [7:0] sense_byte(input logic [4:0] pos, input logic [3:0] key,
    input logic [7:0] asc, input logic [7:0] ascq, input logic pend,
    input logic [7:0] b15, input logic [7:0] b16, input logic [7:0] b17);
    logic [7:0] b;
    b = 8'h00;
    case (pos)
      `RSR_B_ERR: b = pend ? `RSR_ERR_CUR : `RSR_ERR_NONE;
      `RSR_B_KEY: b = {4'h0, key};
      `RSR_B_ALEN: b = `RSR_ADD_LEN;
      `RSR_B_ASC: b = asc;
      `RSR_B_ASCQ: b = ascq;
      `RSR_B_SKS0: b = b15;
      `RSR_B_SKS1: b = b16;
      `RSR_B_SKS2: b = b17;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  wire [4:0] idx_nxt = idx_ff + 5'h01;
  wire [7:0] byte_at_nxt = sense_byte(idx_nxt, s_key, s_asc, s_ascq, snap_pend_ff,
    s_sks0, s_sks1, s_sks2);
  wire [7:0] byte_first = sense_byte(`RSR_B_ERR, s_key, s_asc, s_ascq, snap_pend_ff,
    s_sks0, s_sks1, s_sks2);
  wire take = dout_valid_ff && dout_ready;
  wire last_take = take && dout_last_ff;

  // Transfer sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      RSR_IDLE:
        if (is_sense)
          nxt_state = (alloc_cut == 5'h00) ? RSR_DONE : RSR_SEND;
      RSR_SEND:
        if (last_take)
          nxt_state = RSR_DONE;
      RSR_DONE:
        nxt_state = RSR_IDLE;
      default:
        nxt_state = RSR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= RSR_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Byte counter and length latched at request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_ff <= 5'h00;
      cnt_ff <= 5'h00;
    end
    else if (state_ff == RSR_IDLE && is_sense)
    begin
      idx_ff <= 5'h00;
      cnt_ff <= alloc_cut;
    end
    else if (take)
      idx_ff <= idx_nxt;
  end

  // Output stream; first byte loads one cycle after the snapshot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dout_valid_ff <= 1'b0;
      dout_byte_ff <= 8'h00;
      dout_last_ff <= 1'b0;
    end
    else if (state_ff == RSR_SEND && !dout_valid_ff && idx_ff == 5'h00)
    begin
      dout_valid_ff <= 1'b1;
      dout_byte_ff <= byte_first;
      dout_last_ff <= cnt_ff == 5'h01;
    end
    else if (take)
    begin
      dout_valid_ff <= !dout_last_ff;
      dout_byte_ff <= dout_last_ff ? 8'h00 : byte_at_nxt;
      dout_last_ff <= !dout_last_ff && (idx_nxt + 5'h01 == cnt_ff);
    end
  end

  // One-cycle completion pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_ff <= 1'b0;
    else
      done_ff <= nxt_state == RSR_DONE && state_ff != RSR_DONE;
  end

  // APB decode
  wire apb_acc = psel && penable && !pready_ff;
  wire hit_ctrl = paddr == `RSR_OFF_CTRL;
  wire hit_stat = paddr == `RSR_OFF_STAT;
  wire hit_sel = paddr == `RSR_OFF_SEL;
  wire hit_peek = paddr == `RSR_OFF_PEEK;
  wire hit_any = hit_ctrl || hit_stat || hit_sel || hit_peek;
  wire [3:0] peek_slot = (sel_ff > `RSR_SLOT_ANON) ? `RSR_SLOT_ANON : sel_ff;
  wire [31:0] rd_mux = hit_ctrl ? {29'h0, unit_ff} :
    hit_stat ? {21'h0, pend_ff, state_ff} :
    hit_sel ? {28'h0, sel_ff} :
    hit_peek ? {11'h0, pend_ff[peek_slot], ascq_ff[peek_slot],
      asc_ff[peek_slot], key_ff[peek_slot]} : 32'h0;

  // Registers; one wait state so every answer comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_ff <= `RSR_CTRL_RST;
      sel_ff <= 4'h0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= apb_acc;
      pslverr_ff <= apb_acc && !hit_any;
      prdata_ff <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
      if (apb_acc && pwrite && hit_ctrl)
        unit_ff <= pwdata[2:0];
      if (apb_acc && pwrite && hit_sel)
        sel_ff <= pwdata[3:0];
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign dout_valid = dout_valid_ff;
  assign dout_byte = dout_byte_ff;
  assign dout_last = dout_last_ff;
  assign sense_done = done_ff;
endmodule
`default_nettype wire

// [design/rsr_cfg.svh]
/*
  Constants for the sense responder: register offsets, field codes and sizes.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef RSR_CFG_SVH
`define RSR_CFG_SVH
// Register byte offsets
`define RSR_OFF_CTRL 12'h000
`define RSR_OFF_STAT 12'h004
`define RSR_OFF_SEL 12'h008
`define RSR_OFF_PEEK 12'h00C
// Command block
`define RSR_OPC_SENSE 8'h03
// Sense block sizes and error codes
`define RSR_SENSE_LEN 5'h12
`define RSR_ADD_LEN 8'h0A
`define RSR_ERR_CUR 8'h70
`define RSR_ERR_NONE 8'h00
// Sense keys
`define RSR_KEY_NONE 4'h0
`define RSR_KEY_NRDY 4'h2
`define RSR_KEY_HW 4'h4
`define RSR_KEY_ILL 4'h5
`define RSR_KEY_UATT 4'h6
`define RSR_KEY_ABRT 4'hB
// Wrong unit code pair
`define RSR_ASC_BADLUN 8'h25
`define RSR_ASCQ_BADLUN 8'h00
// Slot of initiators that gave no identifier
`define RSR_SLOT_ANON 4'h8
// Byte positions inside the sense block
`define RSR_B_ERR 5'h00
`define RSR_B_KEY 5'h02
`define RSR_B_ALEN 5'h07
`define RSR_B_ASC 5'h0C
`define RSR_B_ASCQ 5'h0D
`define RSR_B_SKS0 5'h0F
`define RSR_B_SKS1 5'h10
`define RSR_B_SKS2 5'h11
// Control register reset value
`define RSR_CTRL_RST 3'h0
`endif

// [design/rsr_pkg.sv]
/*
  Types shared by the sense responder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package rsr_pkg;
  // Transfer states, Gray along idle, send, done
  typedef enum logic [1:0] {
    RSR_IDLE = 2'b00,
    RSR_SEND = 2'b01,
    RSR_DONE = 2'b11
  } rsr_state_t;
  // Error classes reported by the command blocks
  typedef enum logic [2:0] {
    RSR_EC_NRDY = 3'h0,
    RSR_EC_HW = 3'h1,
    RSR_EC_ILL = 3'h2,
    RSR_EC_UATT = 3'h3,
    RSR_EC_ABRT = 3'h4
  } rsr_ecls_t;
  typedef logic [3:0] rsr_slot_t;
endpackage
`default_nettype wire

// [verif/rsr_responder_asserts.sv]
/* Port checker for the sense responder.
   Assumes one clock pclk and a master that keeps the request order. */
`default_nettype none
module rsr_responder_asserts (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Command
  input wire logic cmd_start,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_alloc_len,
  // Stream
  input wire logic dout_valid,
  input wire logic [7:0] dout_byte,
  input wire logic dout_last,
  input wire logic dout_ready,
  input wire logic sense_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [4:0] want_ff;
  logic [4:0] nxt_want;
  logic take;
  logic go;
  logic zb;
  // Byte position and due count, kept beside the design
  assign take = dout_valid && dout_ready;
  assign go = cmd_start && (cmd_opcode == 8'h03);
  assign nxt_cnt = go ? 5'h00 : (take ? cnt_ff + 5'h01 : cnt_ff);
  assign nxt_want = go ? ((cmd_alloc_len > 8'h12) ? 5'h12 : cmd_alloc_len[4:0]) : want_ff;
  assign zb = (cnt_ff == 5'h01) || (cnt_ff inside {[5'h03:5'h06], [5'h08:5'h0B]}) ||
    (cnt_ff == 5'h0E);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 5'h00;
      want_ff <= 5'h00;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      want_ff <= nxt_want;
    end
  end
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait state");
  property p_zero; !pready |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("read data outside answer");
  property p_start; go && cmd_alloc_len != 8'h00 |-> ##[1:3] dout_valid; endproperty
  a_start: assert property (p_start) else $error("sense bytes did not start");
  property p_len0;
    go && cmd_alloc_len == 8'h00 |=> !dout_valid throughout (##[0:3] sense_done);
  endproperty
  a_len0: assert property (p_len0) else $error("zero length misbehaved");
  property p_last; take |-> dout_last == (cnt_ff + 5'h01 == want_ff); endproperty
  a_last: assert property (p_last) else $error("wrong byte count");
  property p_hold;
    dout_valid && !dout_ready |=> dout_valid && $stable(dout_byte) && $stable(dout_last);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped while stalled");
  property p_byte0; take && cnt_ff == 5'h00 |-> dout_byte inside {8'h00, 8'h70}; endproperty
  a_byte0: assert property (p_byte0) else $error("bad error code byte");
  property p_byte7; take && cnt_ff == 5'h07 |-> dout_byte == 8'h0A; endproperty
  a_byte7: assert property (p_byte7) else $error("bad additional length");
  property p_zeros; take && zb |-> dout_byte == 8'h00; endproperty
  a_zeros: assert property (p_zeros) else $error("unsupported field not zero");
  property p_done; take && dout_last |-> ##[1:3] sense_done; endproperty
  a_done: assert property (p_done) else $error("no done after last byte");
endmodule
bind rsr_responder rsr_responder_asserts rsr_responder_asserts_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .cmd_start(cmd_start), .cmd_opcode(cmd_opcode), .cmd_alloc_len(cmd_alloc_len),
  .dout_valid(dout_valid), .dout_byte(dout_byte), .dout_last(dout_last),
  .dout_ready(dout_ready), .sense_done(sense_done));
`default_nettype wire

// [verif/rsr_init_model.sv]
/* Initiator-side sink of the sense byte stream.
   Assumes the bench pulses clr as each request starts. */
`default_nettype none
module rsr_init_model (
  // Clock and control
  input wire logic pclk,
  input wire logic clr,
  input wire logic slow,
  // Sense stream
  input wire logic dout_valid,
  input wire logic [7:0] dout_byte,
  output logic dout_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx [0:31];
  logic [31:0] rx_n = 32'h0;
  logic rdy_ff = 1'h0;
  // Ready comes from one local flop, so the pin has a single driver
  assign dout_ready = rdy_ff;
  // Slow mode takes every other cycle, so the sender must hold its byte
  always @(posedge pclk)
  begin
    if (clr)
      rx_n <= 32'h0;
    else if (dout_valid && dout_ready)
    begin
      rx[rx_n[4:0]] <= dout_byte;
      rx_n <= rx_n + 32'h1;
    end
    rdy_ff <= !slow || !rdy_ff;
  end
endmodule
`default_nettype wire

// [verif/test_request_sense_responder.sv]
/* Bench for the sense responder: APB master, command driver, sink model.
   Assumes responder, checker and sink model are compiled before it. */
`default_nettype none
module test_request_sense_responder;
  timeunit 1ns;
  timeprecision 1ps;
  import rsr_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic cmd_start = 1'h0, kn_r = 1'h0, err_valid = 1'h0, err_cd = 1'h0, bus_free_err = 1'h0;
  logic bdr_msg = 1'h0, bus_reset = 1'h0, clr = 1'h0, slow = 1'h0, pready, pslverr, rerr;
  logic dout_valid, dout_last, dout_ready, sense_done;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0] cmd_opcode = 8'h0, cmd_alloc_len = 8'h0, err_asc = 8'h0, err_ascq = 8'h0;
  logic [7:0] dout_byte, e_a, e_q, e_s;
  logic [2:0] cmd_lun = 3'h0, cmd_init_id = 3'h0;
  logic [15:0] err_field_ptr = 16'h0, e_f;
  logic [3:0] e_k;
  rsr_ecls_t err_class = RSR_EC_NRDY;
  int fail_count = 0, check_count = 0;
  rsr_responder rsr_responder_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_start(cmd_start), .cmd_opcode(cmd_opcode),
    .cmd_lun(cmd_lun), .cmd_alloc_len(cmd_alloc_len), .cmd_init_id(cmd_init_id),
    .cmd_id_known(kn_r), .err_valid(err_valid), .err_class(err_class), .err_asc(err_asc),
    .err_ascq(err_ascq), .err_cd(err_cd), .err_bpv(1'h1), .err_bit_ptr(3'h6),
    .err_field_ptr(err_field_ptr), .bus_free_err(bus_free_err), .bdr_msg(bdr_msg),
    .bus_reset(bus_reset), .dout_valid(dout_valid), .dout_byte(dout_byte),
    .dout_last(dout_last), .dout_ready(dout_ready), .sense_done(sense_done));
  rsr_init_model rsr_init_model_i (.pclk(pclk), .clr(clr), .slow(slow),
    .dout_valid(dout_valid), .dout_byte(dout_byte), .dout_ready(dout_ready));
  always #5 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // APB transfer; read data and error taken at the pready edge only
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Starts a plain command, then reports one or two errors or a bus free
  task automatic err(input logic [2:0] id, input logic kn, input int c, input logic [7:0] a,
    input logic two, input logic bf);
    @(posedge pclk);
    cmd_start <= 1'h1;
    cmd_opcode <= 8'h00;
    cmd_init_id <= id;
    kn_r <= kn;
    @(posedge pclk);
    cmd_start <= 1'h0;
    err_valid <= !bf;
    bus_free_err <= bf;
    if (two)
    begin
      err_class <= RSR_EC_HW;
      err_asc <= 8'h44;
      @(posedge pclk);
    end
    err_class <= rsr_ecls_t'(c);
    err_asc <= a;
    err_ascq <= a + 8'h01;
    err_cd <= a[0];
    err_field_ptr <= {8'h00, a};
    @(posedge pclk);
    err_valid <= 1'h0;
    bus_free_err <= 1'h0;
  endtask
  task automatic ex(input logic [3:0] k, input logic [7:0] a, q, s, input logic [15:0] f);
    {e_k, e_a, e_q, e_s, e_f} = {k, a, q, s, f};
  endtask
  function automatic logic [7:0] eb(input int i);
    case (i)
      0: eb = (e_k != 4'h0) ? 8'h70 : 8'h00;
      2: eb = {4'h0, e_k};
      7: eb = 8'h0A;
      12: eb = e_a;
      13: eb = e_q;
      15: eb = e_s;
      16: eb = e_f[15:8];
      17: eb = e_f[7:0];
      default: eb = 8'h00;
    endcase
  endfunction
  // Request sense, then compare count and every byte against the expectation
  task automatic sn(input logic [2:0] id, input logic kn, input logic [2:0] lun,
    input logic [7:0] len);
    int n;
    @(posedge pclk);
    {clr, cmd_start, cmd_opcode, cmd_lun, cmd_alloc_len} <= {2'h3, 8'h03, lun, len};
    {cmd_init_id, kn_r} <= {id, kn};
    @(posedge pclk);
    {clr, cmd_start} <= 2'h0;
    n = 0;
    while (sense_done !== 1'h1 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    chk("done", {31'h0, sense_done}, 32'h1);
    chk("count", rsr_init_model_i.rx_n, (len > 8'h12) ? 32'h12 : {24'h0, len});
    for (int i = 0; i < 18 && i < len; i++)
      chk("byte", {24'h0, rsr_init_model_i.rx[i]}, {24'h0, eb(i)});
  endtask
  task automatic t_keys;
    logic [3:0] keys [0:4] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'hB};
    for (int c = 0; c < 5; c++)
      err(c[2:0], 1'h1, c, 8'h10 + c[7:0], 1'h0, 1'h0);
    for (int c = 0; c < 5; c++)
    begin
      ex(keys[c], 8'h10 + c[7:0], 8'h11 + c[7:0], (c == 2) ? 8'h8E : 8'h00,
        (c == 2) ? 16'h0012 : 16'h0);
      sn(c[2:0], 1'h1, 3'h0, 8'h12);
    end
    ex(4'h0, 8'h0, 8'h0, 8'h0, 16'h0);
    sn(3'h0, 1'h1, 3'h0, 8'h12);
    $display("t_keys finished");
  endtask
  task automatic t_misc;
    slow <= 1'h1;
    err(3'h5, 1'h1, 2, 8'h21, 1'h1, 1'h0);
    ex(4'h5, 8'h21, 8'h22, 8'hCE, 16'h0021);
    sn(3'h5, 1'h1, 3'h0, 8'h12);
    ex(4'h0, 8'h0, 8'h0, 8'h0, 16'h0);
    sn(3'h1, 1'h1, 3'h0, 8'h00);
    sn(3'h1, 1'h1, 3'h0, 8'h01);
    sn(3'h1, 1'h1, 3'h0, 8'hFF);
    slow <= 1'h0;
    apb(1'h1, 12'h000, 32'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk("unit", r, 32'h1);
    apb(1'h0, 12'h010, 32'h0);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    chk("unmapped data", r, 32'h0);
    ex(4'h5, 8'h25, 8'h00, 8'h80, 16'h0);
    sn(3'h3, 1'h1, 3'h0, 8'h12);
    apb(1'h1, 12'h000, 32'h0);
    $display("t_misc finished");
  endtask
  task automatic t_clear;
    err(3'h6, 1'h1, 3, 8'h30, 1'h0, 1'h0);
    apb(1'h1, 12'h008, 32'h6);
    apb(1'h0, 12'h00C, 32'h0);
    chk("peek", r, 32'h0013_1306);
    apb(1'h0, 12'h004, 32'h0);
    chk("stat", r, 32'h0000_0100);
    @(posedge pclk);
    bus_reset <= 1'h1;
    @(posedge pclk);
    bus_reset <= 1'h0;
    apb(1'h0, 12'h004, 32'h0);
    chk("stat cleared", r, 32'h0);
    ex(4'h0, 8'h0, 8'h0, 8'h0, 16'h0);
    sn(3'h6, 1'h1, 3'h0, 8'h12);
    err(3'h7, 1'h1, 3, 8'h30, 1'h0, 1'h0);
    @(posedge pclk);
    bdr_msg <= 1'h1;
    @(posedge pclk);
    bdr_msg <= 1'h0;
    sn(3'h7, 1'h1, 3'h0, 8'h12);
    err(3'h2, 1'h0, 4, 8'h40, 1'h0, 1'h0);
    ex(4'hB, 8'h40, 8'h41, 8'h0, 16'h0);
    sn(3'h7, 1'h0, 3'h0, 8'h12);
    err(3'h1, 1'h1, 0, 8'h0, 1'h0, 1'h1);
    ex(4'hB, 8'h0, 8'h0, 8'h0, 16'h0);
    sn(3'h1, 1'h1, 3'h0, 8'h12);
    $display("t_clear finished");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_keys;
    t_misc;
    t_clear;
    report_and_stop;
  end
  // Run needs a few hundred cycles; this cuts a hang
  initial
  begin
    #200000;
    fail_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
